// File: src/pwtc_timer.sv
`timescale 1ns/1ns
`include "pwtc_params.svh"
// Notes on behaviour
// - Mode bits both one select pulse width mode, internal clock gated by pin.
// - Edge select low: count from falling edge until pin returns high, clear run.
// - Edge select high: count from rising edge until pin returns low, clear run.
// - Hardware clears run only in pulse width mode; otherwise software only.
// - After auto stop, hold count and ignore pin until run set again.
// - Pulse width start and stop follow pin transitions, not levels.
// - Three-bit prescale field sets internal clock division.
// - Pin is counter input only in event or pulse mode with share option.
// - Timer mode counts system clock divided by eight times two to the power of the prescale field.
// - Pin edges count at once in event mode; pulse width counts wait for the timer clock pulse.
// - Counter clock inhibited while software reads count or writes preload.
// - Overflow sets request flag; interrupt only when enable is set.
// - Overflow with no flag pending wakes device from power-down regardless of interrupt enable.
// - Event counting continues in power-down and wakes on overflow.
// - Bit 4 of control is run: set starts, clear stops.
// - Mode bits 7 and 6, edge bit 3; 10 timer, 01 event.
// - Overflow reloads preload value and keeps counting.
module pwtc_timer #(
    parameter int CNT_W = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Control register write
    input  wire logic             ctrl_wr_i,
    input  wire logic [7:0]       ctrl_wdata_i,
    // Preload write and counter read
    input  wire logic             preload_wr_i,
    input  wire logic [CNT_W-1:0] preload_wdata_i,
    input  wire logic             count_rd_i,
    // Request flag access
    input  wire logic             flag_set_i,
    input  wire logic             flag_clr_i,
    input  wire logic             irq_en_i,
    // System state and pin
    input  wire logic             pin_share_sel_i,
    input  wire logic             power_down_i,
    input  wire logic             counter_input_pin_i,
    // Status out
    output logic [7:0]            ctrl_o,
    output logic [CNT_W-1:0]      count_o,
    output logic                  request_flag_o,
    output logic                  irq_o,
    output logic                  wake_o
);
    // Refused at elaboration; reset macros and reload path assume this range
    if (CNT_W < 2 || CNT_W > 16) begin : g_cnt_w_chk
        $error("pwtc_timer: CNT_W out of range");
    end

    logic [7:0]       ctrl_q;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] preload_q;
    logic             flag_q;
    logic             irq_q;
    logic             wake_q;
    logic [2:0]       pin_sync_q;
    logic             pin_lvl_q;
    logic             tick;
    logic             overflow;
    logic             inc;
    logic             auto_stop;
    logic             rise;
    logic             fall;
    logic             pin_en;
    logic             start_edge;
    logic             stop_edge;
    pwtc_pkg::pwtc_mode_t     mode;
    pwtc_pkg::pwtc_pw_state_t pw_q;

    // Mode field decoded from the control register
    assign mode = pwtc_pkg::pwtc_mode_t'(
        {ctrl_q[`PWTC_MODE_HI_BIT], ctrl_q[`PWTC_MODE_LO_BIT]});

    // Prescaled tick shared by timer and pulse width modes
    pwtc_tick_gen #(
        .PSC_W (3)
    ) u_tick (
        .clk_i          (clk_i),
        .sys_rst_i      (sys_rst_i),
        .prescale_sel_i (ctrl_q[`PWTC_PSC_MSB:`PWTC_PSC_LSB]),
        .tick_o         (tick)
    );

    // Pin synchroniser; only stages two and three are compared
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_sync_q <= 3'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0],
                           counter_input_pin_i};
        end
    end

    // Accepted level changes when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pin_lvl_q <= 1'b0;
        end else if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_lvl_q <= pin_sync_q[2];
        end
    end

    // Edge detect on the filtered level
    assign rise = (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2]
                  && !pin_lvl_q;
    assign fall = (pin_sync_q[1] == pin_sync_q[2]) && !pin_sync_q[2]
                  && pin_lvl_q;
    assign pin_en = pin_share_sel_i && (mode == pwtc_pkg::PWTC_MODE_EVENT ||
                    mode == pwtc_pkg::PWTC_MODE_PULSE);

    // Start on the chosen edge, stop on the return edge
    assign start_edge = ctrl_q[`PWTC_EDGE_BIT] ? rise : fall;
    assign stop_edge  = ctrl_q[`PWTC_EDGE_BIT] ? fall : rise;

    // Pulse width measurement sequencer, edge driven
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pw_q <= pwtc_pkg::PWTC_PW_ARMED;
        end else if (!ctrl_q[`PWTC_RUN_BIT] ||
                     mode != pwtc_pkg::PWTC_MODE_PULSE || !pin_en) begin
            pw_q <= pwtc_pkg::PWTC_PW_ARMED;
        end else begin
            unique case (pw_q)
                pwtc_pkg::PWTC_PW_ARMED: begin
                    if (start_edge) begin
                        pw_q <= pwtc_pkg::PWTC_PW_MEASURE;
                    end
                end
                pwtc_pkg::PWTC_PW_MEASURE: begin
                    if (stop_edge) begin
                        pw_q <= pwtc_pkg::PWTC_PW_DONE;
                    end
                end
                pwtc_pkg::PWTC_PW_DONE: begin
                    pw_q <= pwtc_pkg::PWTC_PW_DONE;
                end
                // Unused code falls back to waiting for a start edge
                default: begin
                    pw_q <= pwtc_pkg::PWTC_PW_ARMED;
                end
            endcase
        end
    end

    // Return edge while measuring ends the single shot
    assign auto_stop = (pw_q == pwtc_pkg::PWTC_PW_MEASURE) && stop_edge
                       && ctrl_q[`PWTC_RUN_BIT]
                       && mode == pwtc_pkg::PWTC_MODE_PULSE && pin_en;

    // Control register; hardware clear only from pulse width stop
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= `PWTC_CTRL_RST;
        end else if (ctrl_wr_i) begin
            ctrl_q <= ctrl_wdata_i;
        end else if (auto_stop) begin
            ctrl_q[`PWTC_RUN_BIT] <= 1'b0;
        end
    end

    // Increment source per mode; event mode pin edges count without the timer tick
    always_comb begin
        inc = 1'b0;
        unique case (mode)
            pwtc_pkg::PWTC_MODE_TIMER: inc = tick;
            pwtc_pkg::PWTC_MODE_EVENT: inc = pin_en &&
                (ctrl_q[`PWTC_EDGE_BIT] ? fall : rise);
            pwtc_pkg::PWTC_MODE_PULSE: inc = tick &&
                pw_q == pwtc_pkg::PWTC_PW_MEASURE;
            pwtc_pkg::PWTC_MODE_IDLE:  inc = 1'b0;
        endcase
        inc = inc && ctrl_q[`PWTC_RUN_BIT]
              && !count_rd_i && !preload_wr_i;
    end

    // Overflow only on a counting step from full count
    assign overflow = inc && (count_q == {CNT_W{1'b1}});

    // Preload store
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            preload_q <= CNT_W'(`PWTC_CNT_RST);
        end else if (preload_wr_i) begin
            preload_q <= preload_wdata_i;
        end
    end

    // Counter; stopped preload writes go straight in
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            count_q <= CNT_W'(`PWTC_CNT_RST);
        end else if (preload_wr_i && !ctrl_q[`PWTC_RUN_BIT]) begin
            count_q <= preload_wdata_i;
        end else if (overflow) begin
            count_q <= preload_q;
        end else if (inc) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Request flag, set beats clear; irq gated by enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flag_q <= 1'b0;
            irq_q  <= 1'b0;
        end else begin
            flag_q <= overflow || flag_set_i || (flag_q && !flag_clr_i);
            irq_q  <= (overflow || flag_q) && irq_en_i;
        end
    end

    // Wake on overflow in power-down, unless flag already pending
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= overflow && power_down_i && !flag_q;
        end
    end

    // Outputs straight from their registers
    assign ctrl_o         = ctrl_q;
    assign count_o        = count_q;
    assign request_flag_o = flag_q;
    assign irq_o          = irq_q;
    assign wake_o         = wake_q;

    // Overflow side effects: reload, flag, interrupt gate, wake
    a_overflow_reload: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        overflow && !preload_wr_i |=> count_o == $past(preload_q))
        else $error("counter did not reload on overflow");
    a_flag_on_ovf: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        overflow |=> request_flag_o)
        else $error("overflow did not set request flag");
    a_irq_gated: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        irq_o |-> $past(irq_en_i))
        else $error("interrupt raised while disabled");
    a_wake_ovf: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        overflow && power_down_i && !flag_q |=> wake_o)
        else $error("no wake on overflow in power-down");

    // Run bit ownership and single-shot stop
    a_run_hw_clear: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        $fell(ctrl_o[`PWTC_RUN_BIT]) |-> $past(ctrl_wr_i) ||
        $past(mode) == pwtc_pkg::PWTC_MODE_PULSE)
        else $error("run bit cleared outside pulse width mode");
    a_auto_stop: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        auto_stop && !ctrl_wr_i |=> !ctrl_o[`PWTC_RUN_BIT])
        else $error("run bit not cleared at pulse end");

    // Count must hold whenever nothing may clock it
    a_hold_inhibit: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        count_rd_i && !preload_wr_i |=> $stable(count_o))
        else $error("counter moved during read");
    a_hold_stopped: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        !ctrl_o[`PWTC_RUN_BIT] && !preload_wr_i
        |=> $stable(count_o))
        else $error("counter moved while stopped");
    a_timer_tick: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        mode == pwtc_pkg::PWTC_MODE_TIMER && !tick && !preload_wr_i
        |=> $stable(count_o))
        else $error("timer counted without tick");
    a_pin_gate: assert property (
        @(posedge clk_i) disable iff (sys_rst_i)
        mode == pwtc_pkg::PWTC_MODE_EVENT && !pin_share_sel_i && !preload_wr_i
        |=> $stable(count_o))
        else $error("event counted without pin share");
endmodule

// File: src/pwtc_params.svh
`ifndef PWTC_PARAMS_SVH
`define PWTC_PARAMS_SVH
// Control register field positions
`define PWTC_MODE_HI_BIT  7
`define PWTC_MODE_LO_BIT  6
`define PWTC_RUN_BIT      4
`define PWTC_EDGE_BIT     3
`define PWTC_PSC_MSB      2
`define PWTC_PSC_LSB      0
// Reset values
`define PWTC_CTRL_RST     8'h00
`define PWTC_CNT_RST      8'h00
// Timer mode divider, system clock over 8
`define PWTC_TMR_DIV      8
`endif

// File: src/pwtc_pkg.sv
package pwtc_pkg;
    typedef enum logic [1:0] {
        PWTC_MODE_IDLE  = 2'b00,
        PWTC_MODE_EVENT = 2'b01,
        PWTC_MODE_TIMER = 2'b10,
        PWTC_MODE_PULSE = 2'b11
    } pwtc_mode_t;
    typedef enum logic [1:0] {
        PWTC_PW_ARMED,
        PWTC_PW_MEASURE,
        PWTC_PW_DONE
    } pwtc_pw_state_t;
endpackage

// File: src/pwtc_tick_gen.sv
`timescale 1ns/1ns
`include "pwtc_params.svh"
// Prescaled tick source: base divide by 8, then by 2^prescale_sel
module pwtc_tick_gen #(
    parameter int PSC_W = 3
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Control
    input  wire logic [PSC_W-1:0] prescale_sel_i,
    // Tick out
    output logic                  tick_o
);
    localparam int DIV_W = $clog2(`PWTC_TMR_DIV) + (1 << PSC_W);

    // Refused at elaboration; the divider width only covers these selects
    if (PSC_W < 1 || PSC_W > 3) begin : g_psc_w_chk
        $error("pwtc_tick_gen: PSC_W out of range");
    end

    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] limit;

    // Terminal count depends on the selected division
    assign limit = DIV_W'((`PWTC_TMR_DIV << prescale_sel_i) - 1);

    // Free running divider, one tick per period
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            div_q  <= '0;
            tick_o <= 1'b0;
        end else if (div_q >= limit) begin
            div_q  <= '0;
            tick_o <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: tb/pwtc_pin_src.sv
`timescale 1ns/1ns
// External pulse source driving the shared timer input pin
module pwtc_pin_src (
    // Clock for pacing
    input  wire logic clk_i,
    // Pin out
    output logic      pin_o
);
    initial pin_o = 1'b0;

    // Park the pin at a static level
    task automatic park(input logic lvl);
        pin_o = lvl;
    endtask

    // Leave idle, hold for width cycles, return, then rest gap cycles
    task automatic pulse(input logic idle, input int width, input int gap);
        pin_o = ~idle;
        repeat (width) @(posedge clk_i);
        #1 pin_o = idle;
        repeat (gap) @(posedge clk_i);
        #1;
    endtask
endmodule

// File: tb/pulse_width_timer_counter_tb.sv
`timescale 1ns/1ns
module pulse_width_timer_counter_tb;
    logic clk = 1'b0, sys_rst_i = 1'b1, ctrl_wr_i = 1'b0, preload_wr_i = 1'b0;
    logic count_rd_i = 1'b0, flag_set_i = 1'b0, flag_clr_i = 1'b0;
    logic irq_en_i = 1'b0, pin_share_sel_i = 1'b1, power_down_i = 1'b0;
    logic [7:0] ctrl_wdata_i = 8'h00, preload_wdata_i = 8'h00;
    logic [7:0] ctrl_o, count_o, v;
    logic pin, request_flag_o, irq_o, wake_o;
    int error_cnt = 0, total_checks = 0, wake_seen = 0, n;

    pwtc_timer #(.CNT_W(8)) i_pwtc_timer (.clk_i(clk), .sys_rst_i(sys_rst_i),
        .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i),
        .preload_wr_i(preload_wr_i), .preload_wdata_i(preload_wdata_i),
        .count_rd_i(count_rd_i), .flag_set_i(flag_set_i),
        .flag_clr_i(flag_clr_i), .irq_en_i(irq_en_i),
        .pin_share_sel_i(pin_share_sel_i), .power_down_i(power_down_i),
        .counter_input_pin_i(pin), .ctrl_o(ctrl_o), .count_o(count_o),
        .request_flag_o(request_flag_o), .irq_o(irq_o), .wake_o(wake_o));
    pwtc_pin_src i_src (.clk_i(clk), .pin_o(pin));

    // 10 MHz clock
    always #50 clk = ~clk;
    // Wake is a one-cycle pulse, so it is counted on every edge
    always @(posedge clk) if (wake_o === 1'b1) wake_seen++;

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo,
                           input logic [7:0] hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, lo);
        end
    endtask
    // Strobes idle one cycle after each write so back-to-back calls are clean
    task automatic wr_ctrl(input logic [7:0] d);
        ctrl_wr_i = 1'b1;
        ctrl_wdata_i = d;
        cyc(1);
        ctrl_wr_i = 1'b0;
        cyc(1);
    endtask
    task automatic wr_pre(input logic [7:0] d);
        preload_wr_i = 1'b1;
        preload_wdata_i = d;
        cyc(1);
        preload_wr_i = 1'b0;
        cyc(1);
    endtask
    task automatic flag(input logic s);
        flag_set_i = s;
        flag_clr_i = ~s;
        cyc(1);
        flag_set_i = 1'b0;
        flag_clr_i = 1'b0;
        cyc(1);
    endtask
    // Bounded waits on count change and flag rise
    task automatic wait_cnt(output int k);
        logic [7:0] c;
        c = count_o;
        k = 0;
        while (count_o === c && k < 2000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic wait_flag();
        int k;
        k = 0;
        while (request_flag_o !== 1'b1 && k < 2000) begin
            cyc(1);
            k++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watchdog well beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_sim();
    end

    initial begin
        cyc(6);
        sys_rst_i = 1'b0;
        chk({ctrl_o, count_o}, 16'h0000);
        chk(request_flag_o, 1'b0);
        // Timer mode; mode set before run, count loaded while stopped
        wr_ctrl(8'h80);
        wr_pre(8'hfd);
        chk(count_o, 8'hfd);
        irq_en_i = 1'b1;
        for (int p = 0; p < 3; p++) begin
            wr_ctrl(8'h90 | p[7:0]);
            wait_cnt(n);
            wait_cnt(n);
            chk(n, 8 << p);
        end
        chk({request_flag_o, irq_o}, 2'b11);
        // Preload while running only lands at the next overflow
        wr_pre(8'h10);
        flag(1'b0);
        wait_flag();
        chk(count_o, 8'h10);
        // Reading the count freezes it
        count_rd_i = 1'b1;
        v = count_o;
        cyc(100);
        chk(count_o, v);
        count_rd_i = 1'b0;
        wr_ctrl(8'h80);
        v = count_o;
        cyc(80);
        chk({ctrl_o[4], count_o}, {1'b0, v});
        // Pulse width mode, both edge polarities
        for (int e = 0; e < 2; e++) begin
            i_src.park(e[0]);
            wr_ctrl(8'hc0 | (e[7:0] << 3));
            wr_pre(8'h00);
            wr_ctrl(8'hd0 | (e[7:0] << 3));
            cyc(40);
            chk(count_o, 8'h00);
            i_src.park(~e[0]);
            cyc(10);
            wr_ctrl(8'hd0 | (e[7:0] << 3));
            i_src.pulse(~e[0], 80, 40);
            chk(ctrl_o[4], 1'b0);
            chk_rng(count_o, 8'h09, 8'h0b);
            v = count_o;
            i_src.pulse(~e[0], 80, 40);
            chk(count_o, v);
        end
        // Event counting, pin not shared: no counts
        i_src.park(1'b0);
        pin_share_sel_i = 1'b0;
        wr_ctrl(8'h40);
        wr_pre(8'hfe);
        wr_ctrl(8'h50);
        repeat (2) i_src.pulse(1'b0, 4, 8);
        chk(count_o, 8'hfe);
        // Shared pin, power-down, overflow wakes
        pin_share_sel_i = 1'b1;
        power_down_i = 1'b1;
        flag(1'b0);
        wake_seen = 0;
        repeat (2) i_src.pulse(1'b0, 4, 8);
        chk(wake_seen, 1);
        chk({count_o, ctrl_o[4]}, {8'hfe, 1'b1});
        irq_en_i = 1'b0;
        cyc(2);
        chk({request_flag_o, irq_o}, 2'b10);
        // Flag set beforehand keeps the device asleep
        flag(1'b1);
        wake_seen = 0;
        repeat (2) i_src.pulse(1'b0, 4, 8);
        chk(wake_seen, 0);
        flag(1'b0);
        chk(request_flag_o, 1'b0);
        end_sim();
    end
endmodule
